// *** rtl/sadc_defs.vh ***
// sadc_defs.vh: constants for the serial converter readout block
// assumes a 25 MHz system clock; times are in ns unless named otherwise
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH

`define SADC_CLK_PERIOD_NS 40
`define SADC_RESULT_BITS 12
`define SADC_CONVERSION_TIME_NS 1400
`define SADC_ACQUISITION_TIME_NS 600
`define SADC_THROUGHPUT_PERIOD_NS 2000
`define SADC_STROBE_MIN_PULSE_NS 10
`define SADC_CLOCK_AFTER_STROBE_SETUP_NS 10
`define SADC_STROBE_QUIET_TIME_NS 15
`define SADC_WAKE_NAP_NS 50
`define SADC_WAKE_SLEEP_US 1100
// least times round up to whole cycles
`define SADC_CONVERT_STROBE_CYCLES ((`SADC_CONVERSION_TIME_NS + `SADC_CLK_PERIOD_NS - 1) / `SADC_CLK_PERIOD_NS)
`define SADC_WAKE_NAP_CYCLES ((`SADC_WAKE_NAP_NS + `SADC_CLK_PERIOD_NS - 1) / `SADC_CLK_PERIOD_NS)
`define SADC_WAKE_SLEEP_CYCLES ((`SADC_WAKE_SLEEP_US * 1000 + `SADC_CLK_PERIOD_NS - 1) / `SADC_CLK_PERIOD_NS)
`define SADC_NAP_PULSES 2
`define SADC_SLEEP_PULSES 4

`endif

// *** rtl/sadc_sync_edge.v ***
// sadc_sync_edge.v: two-flop synchroniser with edge detection
// assumes an asynchronous pin input and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sadc_sync_edge (
  // clock and reset
  input wire sys_clk_in,
  input wire rst_in,
  // pin and decoded level and edges
  input wire pin_in,
  output wire level_out,
  output wire rise_out,
  output wire fall_out
);
  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  // the first flop feeds only the second, so no logic sees a metastable value
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level_out = sync_reg;
  assign rise_out = sync_reg & ~last_reg;
  assign fall_out = ~sync_reg & last_reg;
endmodule
`default_nettype wire

// *** rtl/sadc_timer.v ***
// sadc_timer.v: load-and-count-down timer with a done level
// assumes load and count value come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module sadc_timer #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire sys_clk_in,
  input wire rst_in,
  // control
  input wire load_in,
  input wire [WIDTH-1:0] count_in,
  // status
  output wire done_out
);
  reg [WIDTH-1:0] count_reg;

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      count_reg <= {WIDTH{1'b0}};
    end else if (load_in) begin
      count_reg <= count_in;
    end else if (count_reg != {WIDTH{1'b0}}) begin
      count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign done_out = (count_reg == {WIDTH{1'b0}});
endmodule
`default_nettype wire

// *** rtl/sadc_core.v ***
// sadc_core.v: conversion control and serial readout of a 12-bit sampler
// assumes convert_strobe and shift clock are host pins, sampled on sys_clk_in
//
// Operation
// RL1 - a rising convert strobe starts a conversion
// RL2 - conversion is timed internally and lasts at least 1400 ns
// RL3 - host spaces conversion starts at least 2000 ns apart
// RL4 - after conversion the device naps by itself
// RL5 - serial output is high impedance while the strobe is high
// RL6 - strobe fall enables the output and shows the msb at once
// RL7 - each later shift clock fall advances to the next bit
// RL8 - bits leave msb first, lsb last
// RL9 - exactly 12 bits, then zeros on further shift clock falls
// RL10 - shifted bits belong to the conversion just finished
// RL11 - strobe low puts the sample-and-hold in tracking
// RL12 - host waits 15 ns after the twelfth fall before raising strobe
// RL13 - host keeps nap or sleep strobe pulses at least 10 ns wide
// RL14 - host raises shift clock no sooner than 10 ns after strobe fall
// RL15 - ready to convert about 50 ns after waking from nap
// RL16 - about 1.1 ms recovery after waking from sleep
// RL17 - two strobe pulses with shift clock static give nap; the code enters nap only at conversion end and leaves NAP_PULSES unused
// RL18 - four strobe pulses with shift clock static give sleep
// RL19 - one shift clock pulse wakes from nap or sleep
// RL20 - host holds strobe high for the whole minimum conversion
`timescale 1ns/1ps
`default_nettype none
`include "sadc_defs.vh"
module sadc_core #(
  parameter RESULT_BITS = `SADC_RESULT_BITS,
  parameter WAKE_SLEEP_CYCLES = `SADC_WAKE_SLEEP_CYCLES
) (
  // clock and reset
  input wire sys_clk_in,
  input wire rst_in,
  // host pins
  input wire convert_strobe_in,
  input wire shift_clk_in,
  output reg serial_out,
  output reg serial_oe_out,
  // analog side: digitised sample from the successive-approximation array
  input wire [RESULT_BITS-1:0] sample_code_in,
  output reg track_out,
  // power and status
  output reg busy_out,
  output reg nap_out,
  output reg sleep_out,
  output reg ready_out
);
  // ==========================================================
  // states
  localparam [4:0] ST_IDLE = 5'b0_0001;
  localparam [4:0] ST_CONVERT_STROBE = 5'b0_0010;
  localparam [4:0] ST_NAP = 5'b0_0100;
  localparam [4:0] ST_SLEEP = 5'b0_1000;
  localparam [4:0] ST_WAKE = 5'b1_0000;
  localparam CW = 16;
  localparam SW = 24;
  localparam [CW-1:0] CONVERT_STROBE_CYC = `SADC_CONVERT_STROBE_CYCLES;
  localparam [SW-1:0] NAP_WAKE_CYC = `SADC_WAKE_NAP_CYCLES;
  localparam [SW-1:0] SLEEP_WAKE_CYC = WAKE_SLEEP_CYCLES;
  localparam [2:0] NAP_PULSES = `SADC_NAP_PULSES;
  localparam [2:0] SLEEP_PULSES = `SADC_SLEEP_PULSES;

  // ==========================================================
  // pin synchronisers
  wire strobe_lvl;
  wire strobe_rise;
  wire strobe_fall;
  wire sck_lvl;
  wire sck_rise;
  wire sck_fall;

  sadc_sync_edge u_strobe_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .pin_in(convert_strobe_in),
    .level_out(strobe_lvl),
    .rise_out(strobe_rise),
    .fall_out(strobe_fall)
  );

  sadc_sync_edge u_sck_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .pin_in(shift_clk_in),
    .level_out(sck_lvl),
    .rise_out(sck_rise),
    .fall_out(sck_fall)
  );

  // ==========================================================
  // conversion and wake timers
  reg [4:0] state_reg;
  reg [4:0] state_next;
  wire convert_strobe_done;
  wire wake_done;
  reg convert_strobe_load;
  reg wake_load;
  reg [SW-1:0] wake_count;

  sadc_timer #(.WIDTH(CW)) u_convert_strobe_timer (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .load_in(convert_strobe_load),
    .count_in(CONVERT_STROBE_CYC),
    .done_out(convert_strobe_done)
  );

  sadc_timer #(.WIDTH(SW)) u_wake_timer (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .load_in(wake_load),
    .count_in(wake_count),
    .done_out(wake_done)
  );

  // ==========================================================
  // power sequence decode and readout registers
  reg [2:0] pulse_cnt_reg;
  reg from_sleep_reg;
  reg [RESULT_BITS-1:0] shift_reg;
  reg [3:0] bits_left_reg;
  reg result_ok_reg;

  // ==========================================================
  // helpers
  // true in the states where a strobe rise may start a conversion
  function is_awake;
    input [4:0] st;
    begin
      is_awake = (st == ST_IDLE) | (st == ST_WAKE);
    end
  endfunction

  // one readout step: the msb leaves and a zero enters at the bottom
  function [RESULT_BITS-1:0] shift_step;
    input [RESULT_BITS-1:0] word;
    begin
      shift_step = {word[RESULT_BITS-2:0], 1'b0};
    end
  endfunction

  // a conversion is accepted only when powered; a rise in nap counts toward sleep
  wire start_ok = strobe_rise & is_awake(state_reg); // RL1

  always @* begin
    state_next = state_reg;
    convert_strobe_load = 1'b0;
    wake_load = 1'b0;
    wake_count = NAP_WAKE_CYC;
    case (state_reg)
      ST_IDLE: begin
        if (strobe_rise) begin
          convert_strobe_load = 1'b1; // RL2
          state_next = ST_CONVERT_STROBE; // RL1
        end
      end
      ST_CONVERT_STROBE: begin
        // the conversion timer on sys_clk_in ends the conversion, then nap without host help
        if (convert_strobe_done) begin
          state_next = ST_NAP; // RL4
        end
      end
      ST_NAP: begin
        if (sck_rise) begin
          wake_load = 1'b1; // RL19
          wake_count = NAP_WAKE_CYC; // RL15
          state_next = ST_WAKE;
        end else if (strobe_rise && pulse_cnt_reg == SLEEP_PULSES - 3'd1) begin
          state_next = ST_SLEEP; // RL18
        end
      end
      ST_SLEEP: begin
        if (sck_rise) begin
          wake_load = 1'b1; // RL19
          wake_count = SLEEP_WAKE_CYC; // RL16
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // a strobe during recovery still converts; accuracy is the host's worry
        if (strobe_rise) begin
          convert_strobe_load = 1'b1;
          state_next = ST_CONVERT_STROBE;
        end else if (wake_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // state, pulse counter and readout
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      pulse_cnt_reg <= 3'd0;
      from_sleep_reg <= 1'b0;
      shift_reg <= {RESULT_BITS{1'b0}};
      bits_left_reg <= 4'd0;
      result_ok_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_SLEEP) begin
        from_sleep_reg <= 1'b1;
      end else if (state_reg == ST_IDLE) begin
        from_sleep_reg <= 1'b0;
      end
      // strobe pulses are counted only while the shift clock stays static
      if (sck_rise | sck_fall | start_ok) begin
        pulse_cnt_reg <= 3'd0;
      end else if (strobe_rise && pulse_cnt_reg != SLEEP_PULSES) begin
        pulse_cnt_reg <= pulse_cnt_reg + 3'd1; // RL17
      end
      // capture at conversion end so readout has no latency
      if (state_reg == ST_CONVERT_STROBE && convert_strobe_done) begin
        shift_reg <= sample_code_in; // RL10
        result_ok_reg <= 1'b1;
      end else if (strobe_fall) begin
        bits_left_reg <= RESULT_BITS[3:0]; // RL6
      end else if (sck_fall && !strobe_lvl) begin
        shift_reg <= shift_step(shift_reg); // RL7 RL8
        if (bits_left_reg != 4'd0) begin
          bits_left_reg <= bits_left_reg - 4'd1;
        end
      end
      if (strobe_rise) begin
        result_ok_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // registered outputs
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      serial_out <= 1'b0;
      serial_oe_out <= 1'b0;
      track_out <= 1'b1;
      busy_out <= 1'b0;
      nap_out <= 1'b0;
      sleep_out <= 1'b0;
      ready_out <= 1'b1;
    end else begin
      serial_oe_out <= ~strobe_lvl & ~strobe_rise; // RL5 RL6
      // shift_reg fills with zeros, so bits past the twelfth read zero
      serial_out <= strobe_lvl ? 1'b0 : shift_reg[RESULT_BITS-1]; // RL9
      track_out <= ~strobe_lvl; // RL11
      busy_out <= (state_next == ST_CONVERT_STROBE);
      nap_out <= (state_next == ST_NAP);
      sleep_out <= (state_next == ST_SLEEP);
      ready_out <= (state_next == ST_IDLE);
    end
  end
endmodule
`default_nettype wire

// *** testbench/sadc_core_checker.sv ***
// checker: pin timing of the readout block, bound to sadc_core
// assumes pins change away from clock edges and pass a two-flop sync
`timescale 1ns/1ps
`default_nettype none
module sadc_core_checker #(
  parameter WAKE_SLEEP_CYCLES = 27500
) (
  // clock and reset
  input wire sys_clk_in,
  input wire rst_in,
  // pins and status
  input wire convert_strobe_in,
  input wire shift_clk_in,
  input wire serial_out,
  input wire serial_oe_out,
  input wire track_out,
  input wire busy_out,
  input wire nap_out,
  input wire sleep_out,
  input wire ready_out
);
  // 35 timer cycles plus the load cycle in which busy is already raised
  localparam int CONVERT_STROBE_CYC = 36;
  logic sck_reg;
  logic [5:0] convert_strobe_reg;
  logic [3:0] falls_reg;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ==========
  // raw pin counts; checks leave room for the sync delay
  always @(posedge sys_clk_in) begin
    sck_reg <= shift_clk_in;
    convert_strobe_reg <= (rst_in || !busy_out) ? 6'h0 : convert_strobe_reg + 6'h1;
    if (rst_in || convert_strobe_in) falls_reg <= 4'h0;
    else if (sck_reg && !shift_clk_in && falls_reg != 4'hf) falls_reg <= falls_reg + 4'h1;
  end
  // ==========
  // checks
  a_hiz_strobe: assert property (convert_strobe_in [*5] |-> !serial_oe_out)
    else $error("output driven under strobe");
  a_start_busy: assert property ($rose(convert_strobe_in) && ready_out |-> ##[2:5] busy_out)
    else $error("no conversion start");
  a_convert_strobe_len: assert property ($fell(busy_out) |-> convert_strobe_reg == CONVERT_STROBE_CYC && nap_out)
    else $error("bad conversion end");
  a_msb_enable: assert property (
    $fell(convert_strobe_in) ##1 (!convert_strobe_in) [*4] |-> serial_oe_out)
    else $error("output not enabled");
  a_track_hold: assert property (convert_strobe_in [*5] |-> !track_out)
    else $error("tracking under strobe");
  a_shift_step: assert property (
    $changed(serial_out) && serial_oe_out && $past(serial_oe_out)
    |-> $past(shift_clk_in, 5) && !$past(shift_clk_in, 2))
    else $error("output moved without fall");
  a_zero_tail: assert property ((falls_reg > 4'hb) [*5] |-> !serial_out)
    else $error("no trailing zero");
  a_nap_wake: assert property (
    $rose(shift_clk_in) && nap_out && !sleep_out |-> ##[2:6] ready_out)
    else $error("slow nap wake");
endmodule
bind sadc_core sadc_core_checker #(.WAKE_SLEEP_CYCLES(WAKE_SLEEP_CYCLES)) chk (.*);
`default_nettype wire

// *** testbench/sadc_host_model.sv ***
// host model: strobe and shift clock pins, reads the serial line
// assumes the device samples pins on sys_clk_in; shift clock idles low
`timescale 1ns/1ps
`default_nettype none
module sadc_host_model (
  // clock and serial line
  input wire sys_clk_in,
  input wire serial_in,
  input wire serial_oe_in,
  // host pins
  output logic convert_strobe_out,
  output logic shift_clk_out
);
  logic last_reg = 1'b0;
  // no pull on the line, so a released line shows the inverse level
  wire line = serial_oe_in ? serial_in : ~last_reg;
  always @(posedge sys_clk_in) last_reg <= line;
  initial begin
    convert_strobe_out = 1'b0;
    shift_clk_out = 1'b0;
  end
  // ==========
  // long pulse holds a conversion, short ones command power states
  task automatic pulses(input int n, input int hold);
    repeat (n) begin
      @(posedge sys_clk_in) convert_strobe_out <= 1'b1;
      repeat (hold) @(posedge sys_clk_in);
      convert_strobe_out <= 1'b0;
      repeat (5) @(posedge sys_clk_in);
    end
    @(negedge sys_clk_in);
  endtask
  // sampled on the falling clock edge just before each fall, well after the output settles
  task automatic read(output logic [13:0] word);
    word = 14'h0;
    repeat (4) @(posedge sys_clk_in);
    repeat (14) begin
      shift_clk_out <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      @(negedge sys_clk_in) word = {word[12:0], line};
      @(posedge sys_clk_in) shift_clk_out <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
    end
    @(negedge sys_clk_in);
  endtask
  task automatic wake();
    @(posedge sys_clk_in) shift_clk_out <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    shift_clk_out <= 1'b0;
    @(negedge sys_clk_in);
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// testbench top: readout block, host model and expected-bit queue
// assumes 25 MHz and a short sleep wake count
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [11:0] sample_code_in = 12'h0;
  logic [13:0] word;
  logic [13:0] exp;
  logic q[$];
  int failures = 0;
  int cmp_count = 0;
  wire convert_strobe_in, shift_clk_in, serial_out, serial_oe_out;
  wire track_out, busy_out, nap_out, sleep_out, ready_out;
  always #20 sys_clk_in = ~sys_clk_in;
  sadc_core #(.WAKE_SLEEP_CYCLES(20)) uut (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .convert_strobe_in(convert_strobe_in),
    .shift_clk_in(shift_clk_in),
    .serial_out(serial_out),
    .serial_oe_out(serial_oe_out),
    .sample_code_in(sample_code_in),
    .track_out(track_out),
    .busy_out(busy_out),
    .nap_out(nap_out),
    .sleep_out(sleep_out),
    .ready_out(ready_out)
  );
  sadc_host_model host (.sys_clk_in(sys_clk_in), .serial_in(serial_out),
    .serial_oe_in(serial_oe_out), .convert_strobe_out(convert_strobe_in),
    .shift_clk_out(shift_clk_in));
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check_word(input string what, input logic [13:0] e, input logic [13:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check_flag(input string what, input logic e, input logic g);
    check_word(what, {13'h0, e}, {13'h0, g});
  endtask
  task automatic wait_ready(input int limit);
    for (int n = 0; n < limit && ready_out !== 1'b1; n++) @(negedge sys_clk_in);
    check_flag("ready", 1'b1, ready_out);
    if (ready_out !== 1'b1) summarize();
  endtask
  initial begin
    void'($urandom(32'hc296_02b8));
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    // ==========
    // back-to-back frames, read two bits past the result
    for (int f = 0; f < 3; f++) begin
      @(posedge sys_clk_in) sample_code_in <= 12'($urandom);
      host.pulses(1, 45);
      check_flag("nap", 1'b1, nap_out);
      host.read(word);
      for (int i = 11; i >= 0; i--) q.push_back(sample_code_in[i]);
      q.push_back(1'b0);
      q.push_back(1'b0);
      exp = 14'h0;
      while (q.size() > 0) exp = {exp[12:0], q.pop_front()};
      check_word("frame", exp, word);
      check_flag("ready", 1'b1, ready_out);
      $display("test frame %0d done", f);
    end
    // ==========
    // power states: two pulses keep nap, four reach sleep
    host.pulses(1, 45);
    host.pulses(2, 5);
    check_flag("nap", 1'b1, nap_out);
    check_flag("sleep", 1'b0, sleep_out);
    host.wake();
    wait_ready(8);
    $display("test nap done");
    host.pulses(1, 45);
    host.pulses(4, 5);
    check_flag("sleep", 1'b1, sleep_out);
    host.wake();
    repeat (10) @(negedge sys_clk_in);
    check_flag("early ready", 1'b0, ready_out);
    wait_ready(40);
    $display("test sleep done");
    summarize();
  end
endmodule
`default_nettype wire
